// [src/crc_scan_pkg.sv]
// Package with register map, fields, reset values and modes of the CRC scanner block
package crc_scan_pkg;
   // Register byte addresses, one aligned word each
   localparam logic [11:0] ADDR_ACCUM_HIGH = 12'h000;
   localparam logic [11:0] ADDR_ACCUM_LOW = 12'h004;
   localparam logic [11:0] ADDR_SHIFTER_HIGH = 12'h008;
   localparam logic [11:0] ADDR_SHIFTER_LOW = 12'h00c;
   localparam logic [11:0] ADDR_POLY_HIGH = 12'h010;
   localparam logic [11:0] ADDR_POLY_LOW = 12'h014;
   localparam logic [11:0] ADDR_SCAN_CTRL = 12'h018;
   localparam logic [11:0] ADDR_CUR_HIGH = 12'h01c;
   localparam logic [11:0] ADDR_CUR_LOW = 12'h020;
   localparam logic [11:0] ADDR_END_HIGH = 12'h024;
   localparam logic [11:0] ADDR_END_LOW = 12'h028;
   localparam logic [11:0] ADDR_TRIG = 12'h02c;
   // Control register fields
   localparam int CTRL_EN = 7;
   localparam int CTRL_RUN = 6;
   localparam int CTRL_BUSY = 5;
   localparam int CTRL_INVALID = 4;
   localparam int CTRL_HOLD = 3;
   localparam int CTRL_MODE_HI = 1;
   localparam logic [7:0] CTRL_WR_MASK = 8'hcb;
   localparam logic [7:0] POLY_LOW_FIXED = 8'h01;
   localparam logic [15:0] POLY_RESET = 16'h0001;
   localparam logic [15:0] ZERO16 = 16'h0000;
   localparam logic [7:0] ZERO8 = 8'h00;
   localparam logic [3:0] TRIG_LAST = 4'h9;
   localparam logic [16:0] FLASH_WORDS = 17'h04000;
   typedef enum logic [1:0] {
      MODE_CONCURRENT = 2'b00,
      MODE_BURST = 2'b01,
      MODE_PEEK = 2'b10,
      MODE_TRIGGERED = 2'b11
   } access_mode_t;
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_FETCH = 2'b01,
      ST_HAND = 2'b10
   } scan_state_t;
endpackage

// [src/crc_scanner.sv]
// CRC result registers and program memory scanner with APB register access
//
// The APB interface to the registers and the register offsets were decided locally.
`timescale 1ns/10ps
`default_nettype none
module crc_scanner
   import crc_scan_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rstn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [15:0] crc_accum_in,
   input wire logic [15:0] crc_shift_in,
   input wire logic crc_ready,
   output logic crc_data_valid,
   output logic [15:0] crc_data,
   output logic accum_load,
   output logic [15:0] accum_load_value,
   output logic [15:0] poly_taps,
   output logic flash_req,
   output logic [15:0] flash_addr,
   input wire logic flash_ack,
   input wire logic [15:0] flash_rdata,
   input wire logic irq_active,
   input wire logic [9:0] trigger_in,
   output logic cpu_stall
);
   ////////////////////////////////////////////////////////////////////////////
   typedef struct packed {
      logic [15:0] poly;
      logic en;
      logic run;
      logic hold;
      logic [1:0] mode;
      logic [15:0] cur;
      logic [15:0] last;
      logic [3:0] trig;
      scan_state_t st;
      logic [31:0] rdata;
      logic ready;
      logic err;
      logic dvalid;
      logic [15:0] data;
      logic aload;
      logic [15:0] aval;
      logic req;
      logic stall;
      logic busy;
      logic invalid;
   } state_t;

   state_t s;
   state_t next_s;
   logic rst_meta;
   logic rst_sync;

   // Reset release through two flops
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         rst_meta <= 1'b0;
         rst_sync <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_sync <= rst_meta;
      end
   end

   function automatic logic addr_invalid(input logic [15:0] a);
      addr_invalid = ({1'b0, a} >= FLASH_WORDS);
   endfunction

   function automatic logic [15:0] put_byte(input logic [15:0] v, input logic hi,
                                            input logic [7:0] b);
      put_byte = hi ? {b, v[7:0]} : {v[15:8], b};
   endfunction

   // Reserved selector codes match no source and never fire
   function automatic logic trigger_hit(input logic [9:0] t, input logic [3:0] sel);
      trigger_hit = 1'b0;
      for (int i = 0; i < $bits(t); i++) begin
         if (sel == 4'(i)) begin
            trigger_hit = t[i];
         end
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   logic access;
   logic wr;
   logic rd_ok;
   logic [7:0] rbyte;
   logic [7:0] wb;
   logic hold_now;
   logic run_eff;
   logic past_end;
   logic trig_ok;
   logic go;

   always_comb begin
      next_s = s;
      access = psel && penable && !s.ready;
      wr = access && pwrite;
      wb = pwdata[7:0];
      rd_ok = 1'b1;
      rbyte = ZERO8;
      unique case (paddr)
         ADDR_ACCUM_HIGH: rbyte = crc_accum_in[15:8];
         ADDR_ACCUM_LOW: rbyte = crc_accum_in[7:0];
         ADDR_SHIFTER_HIGH: rbyte = crc_shift_in[15:8];
         ADDR_SHIFTER_LOW: rbyte = crc_shift_in[7:0];
         ADDR_POLY_HIGH: rbyte = s.poly[15:8];
         ADDR_POLY_LOW: rbyte = s.poly[7:0] | POLY_LOW_FIXED;
         ADDR_SCAN_CTRL: rbyte = {s.en, s.run, s.busy, s.invalid, s.hold, 1'b0,
                                  s.mode};
         ADDR_CUR_HIGH: rbyte = s.cur[15:8];
         ADDR_CUR_LOW: rbyte = s.cur[7:0];
         ADDR_END_HIGH: rbyte = s.last[15:8];
         ADDR_END_LOW: rbyte = s.last[7:0];
         ADDR_TRIG: rbyte = {4'h0, s.trig};
         default: rd_ok = 1'b0;
      endcase
      // APB answer one cycle after the access phase begins
      next_s.ready = access;
      next_s.err = access && !rd_ok;
      next_s.rdata = (access && !pwrite) ? {24'h000000, rbyte} : 32'h00000000;
      next_s.aload = 1'b0;
      next_s.aval = s.aval;

      // Run bit masked during interrupts when hold is selected, except in peek
      hold_now = irq_active && s.hold && (access_mode_t'(s.mode) != MODE_PEEK);
      run_eff = s.en && s.run && !hold_now;
      past_end = s.cur > s.last;
      trig_ok = (access_mode_t'(s.mode) != MODE_TRIGGERED) ||
                trigger_hit(trigger_in, s.trig);
      go = run_eff && crc_ready && !past_end && trig_ok;

      next_s.dvalid = 1'b0;
      next_s.req = s.req;
      unique case (s.st)
         ST_IDLE: begin
            if (go) begin
               next_s.req = 1'b1;
               next_s.st = ST_FETCH;
            end
         end
         ST_FETCH: begin
            if (flash_ack) begin
               next_s.req = 1'b0;
               next_s.data = flash_rdata;
               next_s.dvalid = 1'b1;
               next_s.cur = s.cur + 16'h0001;
               next_s.st = ST_HAND;
            end
         end
         ST_HAND: begin
            // Wait for ready to drop so one word goes per handshake
            if (!crc_ready) begin
               next_s.st = ST_IDLE;
            end
         end
         default: next_s.st = ST_IDLE;
      endcase

      // Run bit cleared by hardware past the end with no cycle active
      if (s.run && past_end && s.st == ST_IDLE) begin
         next_s.run = 1'b0;
      end

      if (wr) begin
         unique case (paddr)
            ADDR_ACCUM_HIGH: begin
               next_s.aload = 1'b1;
               next_s.aval = put_byte(crc_accum_in, 1'b1, wb);
            end
            ADDR_ACCUM_LOW: begin
               next_s.aload = 1'b1;
               next_s.aval = put_byte(crc_accum_in, 1'b0, wb);
            end
            ADDR_SHIFTER_HIGH, ADDR_SHIFTER_LOW: next_s.aload = 1'b0;
            ADDR_POLY_HIGH: next_s.poly = put_byte(s.poly, 1'b1, wb);
            ADDR_POLY_LOW: next_s.poly = put_byte(s.poly, 1'b0, wb | POLY_LOW_FIXED);
            ADDR_SCAN_CTRL: begin
               next_s.en = wb[CTRL_EN];
               // Software value overrides a hardware clear in the same cycle
               next_s.run = wb[CTRL_RUN];
               next_s.hold = wb[CTRL_HOLD];
               next_s.mode = wb[CTRL_MODE_HI:0];
            end
            ADDR_CUR_HIGH: if (!s.run) next_s.cur = put_byte(s.cur, 1'b1, wb);
            ADDR_CUR_LOW: if (!s.run) next_s.cur = put_byte(s.cur, 1'b0, wb);
            ADDR_END_HIGH: if (!s.run) next_s.last = put_byte(s.last, 1'b1, wb);
            ADDR_END_LOW: if (!s.run) next_s.last = put_byte(s.last, 1'b0, wb);
            ADDR_TRIG: next_s.trig = wb[3:0];
            default: next_s.err = 1'b1;
         endcase
      end
      // Disabling resets only the sequencer, never the registers
      if (!next_s.en) begin
         next_s.st = ST_IDLE;
         next_s.req = 1'b0;
      end

      next_s.busy = (next_s.st != ST_IDLE) || (next_s.en && crc_ready);
      next_s.invalid = addr_invalid(next_s.cur);
      next_s.stall = next_s.en && next_s.run && !(next_s.cur > next_s.last) &&
                     (access_mode_t'(next_s.mode) == MODE_BURST) &&
                     !(irq_active && next_s.hold);
   end

   always_ff @(posedge clk_sys or negedge rst_sync) begin
      if (!rst_sync) begin
         s <= '0;
         s.poly <= POLY_RESET;
         s.st <= ST_IDLE;
      end else begin
         s <= next_s;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   assign prdata = s.rdata;
   assign pready = s.ready;
   assign pslverr = s.err;
   assign crc_data_valid = s.dvalid;
   assign crc_data = s.data;
   assign accum_load = s.aload;
   assign accum_load_value = s.aval;
   assign poly_taps = s.poly;
   assign flash_req = s.req;
   assign flash_addr = s.cur;
   assign cpu_stall = s.stall;

   ////////////////////////////////////////////////////////////////////////////
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_sync);

   sequence fetch_done;
      s.st == ST_FETCH && flash_ack;
   endsequence

   sequence fetch_start;
      s.st == ST_IDLE && go;
   endsequence

   sequence hand_wait;
      s.st == ST_HAND && crc_ready;
   endsequence

   addr_step_a: assert property (fetch_done |=> s.cur == $past(s.cur) + 16'h0001)
      else $error("address did not step after fetch");

   word_pass_a: assert property (
      fetch_done |=> crc_data_valid && crc_data == $past(flash_rdata))
      else $error("fetched word not handed on");
   one_word_a: assert property (crc_data_valid |=> !crc_data_valid)
      else $error("two words in one handshake");
   disable_idle_a: assert property (!s.en |-> s.st == ST_IDLE && !flash_req)
      else $error("sequencer active while disabled");

   cur_lock_a: assert property (s.run && s.st != ST_FETCH |=> s.cur == $past(s.cur))
      else $error("address moved while locked");
   end_clear_a: assert property (s.run && s.cur > s.last && s.st == ST_IDLE && !wr
                                 |=> !s.run)
      else $error("run bit not cleared past end");
   hold_mask_a: assert property (s.st == ST_IDLE && irq_active && s.hold &&
                                 s.mode != MODE_PEEK |=> s.st == ST_IDLE)
      else $error("fetch started during held interrupt");
   low_bit_a: assert property (s.poly[0])
      else $error("polynomial bit 0 not one");
   invalid_flag_a: assert property (##1 s.invalid == addr_invalid(s.cur))
      else $error("invalid flag wrong");
   apb_answer_a: assert property (psel && penable && !pready |=> pready ##1 !pready)
      else $error("apb answer timing wrong");

   // Fetch sequencing and handshake
   req_rise_a: assert property (fetch_start |=> flash_req && s.st == ST_FETCH)
      else $error("fetch request not raised");

   hand_wait_a: assert property (hand_wait |=> !flash_req && s.st != ST_FETCH)
      else $error("new fetch before ready dropped");

   run_busy_a: assert property (s.run && s.st != ST_IDLE && !wr |=> s.run)
      else $error("run bit cleared during a data cycle");

   busy_flag_a: assert property (s.st != ST_IDLE |-> s.busy)
      else $error("busy low during a scan cycle");

   // Mode and interrupt handling
   peek_go_a: assert property (
      s.st == ST_IDLE && s.en && s.run && crc_ready && !(s.cur > s.last) &&
      s.mode == MODE_PEEK && !wr |=> s.st == ST_FETCH)
      else $error("peek fetch held back");

   stall_mode_a: assert property (cpu_stall |-> s.en && s.run && s.mode == MODE_BURST)
      else $error("stall outside a burst");

   stall_irq_a: assert property (cpu_stall |-> !(s.hold && $past(irq_active)))
      else $error("stall kept during held interrupt");

   trig_gate_a: assert property (
      s.st == ST_IDLE && s.mode == MODE_TRIGGERED && !trigger_hit(trigger_in, s.trig)
      |=> s.st == ST_IDLE)
      else $error("triggered fetch without its trigger");

   // Register locks and bus view
   end_lock_a: assert property (s.run |=> s.last == $past(s.last))
      else $error("end address moved while running");

   accum_load_a: assert property (
      wr && paddr == ADDR_ACCUM_LOW |=>
      accum_load && accum_load_value[7:0] == $past(pwdata[7:0]))
      else $error("accumulator low byte not loaded");

   ctrl_bit2_a: assert property (
      psel && penable && !pready && !pwrite && paddr == ADDR_SCAN_CTRL |=> !prdata[2])
      else $error("control bit 2 read as one");
endmodule
`default_nettype wire

// [verif/flash_crc_model.sv]
// Program flash and CRC engine model facing the scanner
`timescale 1ns/10ps
`default_nettype none
module flash_crc_model (
   input wire logic clk_sys,
   input wire logic rstn,
   input wire logic rdy_en,
   input wire logic slow,
   input wire logic flash_req,
   input wire logic [15:0] flash_addr,
   input wire logic crc_data_valid,
   input wire logic [15:0] crc_data,
   input wire logic accum_load,
   input wire logic [15:0] accum_load_value,
   output logic crc_ready,
   output logic flash_ack,
   output logic [15:0] flash_rdata,
   output logic [15:0] crc_accum_in,
   output logic [15:0] crc_shift_in,
   output logic [15:0] cnt
);
   logic [2:0] wt;
   logic [2:0] gap;
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         {crc_ready, flash_ack, wt, gap} <= '0;
         {flash_rdata, crc_accum_in, crc_shift_in, cnt} <= '0;
      end else begin
         flash_ack <= 1'b0;
         // Read data is inverted every cycle outside the acknowledge cycle
         flash_rdata <= ~flash_rdata;
         if (flash_req && !flash_ack) begin
            if (wt >= (slow ? 3'd3 : 3'd0)) begin
               flash_ack <= 1'b1;
               flash_rdata <= flash_addr ^ 16'h5a5a;
               wt <= 3'd0;
            end else begin
               wt <= wt + 3'd1;
            end
         end
         if (crc_data_valid) begin
            cnt <= cnt + 16'h1;
            crc_shift_in <= crc_data;
            gap <= 3'd2;
         end else if (gap != 3'd0) begin
            gap <= gap - 3'd1;
         end
         crc_ready <= rdy_en && gap == 3'd0 && !crc_data_valid;
         if (accum_load) begin
            crc_accum_in <= accum_load_value;
         end
      end
   end
endmodule
`default_nettype wire

// [verif/tb_crc_result_and_memory_scanner.sv]
// Testbench for the CRC result registers and memory scanner
`timescale 1ns/10ps
`default_nettype none
module tb_crc_result_and_memory_scanner;
   import crc_scan_pkg::*;
   logic clk_sys = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
   logic crc_ready, crc_data_valid, accum_load, flash_req, flash_ack, cpu_stall;
   logic irq_active = 0, rdy_en = 1, slow = 0, stall_seen = 0, err;
   logic [11:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata;
   logic [15:0] crc_accum_in, crc_shift_in, crc_data, accum_load_value, poly_taps;
   logic [15:0] flash_addr, flash_rdata, cnt;
   logic [9:0] trigger_in = 0;
   logic [7:0] q;
   int n_errors = 0, checks = 0;
   crc_scanner DUT (.*);
   flash_crc_model partner (.*);
   initial forever #12.5 clk_sys = ~clk_sys;
   always @(posedge clk_sys) if (cpu_stall === 1'b1) stall_seen <= 1'b1;
   ////////////////////////////////////////////////////////////////////////////
   task test_done;
      $display("errors %0d checks %0d", n_errors, checks);
      if (n_errors == 0 && checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task automatic bus(input logic w, input logic [11:0] a, input logic [7:0] d);
      int n = 0;
      @(posedge clk_sys);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h0, d};
      @(posedge clk_sys);
      penable <= 1'b1;
      do begin
         @(posedge clk_sys);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1) begin
         n_errors++;
         $display("[FAIL] pready expected 1 seen %b", pready);
      end
      q = prdata[7:0];
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task chk(input string s, input logic [15:0] e, input logic [15:0] g);
      checks++;
      if (g !== e) begin
         n_errors++;
         $display("[FAIL] %s expected %h seen %h", s, e, g);
      end
   endtask
   task rd(input logic [11:0] a, input string s, input logic [7:0] e);
      bus(0, a, 8'h00);
      chk(s, {8'h0, e}, {8'h0, q});
   endtask
   task w16(input logic [11:0] a, input logic [15:0] v);
      bus(1, a, v[15:8]);
      bus(1, a + 12'h4, v[7:0]);
   endtask
   // Loads the window and starts, then polls until hardware stops the run
   task automatic scan(input logic [15:0] lo, input logic [15:0] hi, input logic [7:0] c);
      int n = 0;
      w16(ADDR_CUR_HIGH, lo);
      w16(ADDR_END_HIGH, hi);
      bus(1, ADDR_SCAN_CTRL, c);
      do begin
         bus(0, ADDR_SCAN_CTRL, 8'h00);
         n++;
      end while (q[CTRL_RUN] !== 1'b0 && n < 100);
      chk("run_end", 16'h0, {15'h0, q[CTRL_RUN]});
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (20000) @(posedge clk_sys);
      n_errors++;
      test_done;
   end
   initial begin
      repeat (12) @(posedge clk_sys);
      rstn <= 1;
      repeat (4) @(posedge clk_sys);
      rd(ADDR_ACCUM_HIGH, "acc_h", 8'h00);
      rd(ADDR_SHIFTER_LOW, "sh_l", 8'h00);
      rd(ADDR_POLY_LOW, "poly_l", 8'h01);
      rd(ADDR_CUR_LOW, "cur_l", 8'h00);
      w16(ADDR_ACCUM_HIGH, 16'habcd);
      rd(ADDR_ACCUM_HIGH, "acc_h", 8'hab);
      rd(ADDR_ACCUM_LOW, "acc_l", 8'hcd);
      bus(1, ADDR_SHIFTER_HIGH, 8'hff);
      rd(ADDR_SHIFTER_HIGH, "sh_h", 8'h00);
      w16(ADDR_POLY_HIGH, 16'h8004);
      rd(ADDR_POLY_LOW, "poly_l", 8'h05);
      chk("taps", 16'h8005, poly_taps);
      bus(1, ADDR_SCAN_CTRL, 8'h04);
      rd(ADDR_SCAN_CTRL, "ctrl", 8'h00);
      bus(1, 12'h030, 8'h11);
      chk("slverr", 16'h1, {15'h0, err});
      scan(16'h0010, 16'h0012, 8'hc0);
      chk("words", 16'd3, cnt);
      rd(ADDR_SHIFTER_LOW, "sh_l", 8'h48);
      rd(ADDR_CUR_LOW, "cur_l", 8'h13);
      chk("no_stall", 16'h0, {15'h0, stall_seen});
      slow <= 1;
      scan(16'h0020, 16'h0021, 8'hc1);
      chk("stall", 16'h1, {15'h0, stall_seen});
      chk("words", 16'd5, cnt);
      irq_active <= 1;
      w16(ADDR_CUR_HIGH, 16'h0030);
      w16(ADDR_END_HIGH, 16'h0031);
      bus(1, ADDR_SCAN_CTRL, 8'hc8);
      repeat (30) @(posedge clk_sys);
      chk("held", 16'd5, cnt);
      bus(0, ADDR_SCAN_CTRL, 8'h00);
      chk("run", 16'h1, {15'h0, q[CTRL_RUN]});
      irq_active <= 0;
      scan(16'h0000, 16'h0000, 8'hc8);
      chk("words", 16'd7, cnt);
      rd(ADDR_CUR_LOW, "cur_l", 8'h32);
      irq_active <= 1;
      scan(16'h0040, 16'h0040, 8'hca);
      chk("words", 16'd8, cnt);
      irq_active <= 0;
      bus(1, ADDR_TRIG, 8'h03);
      trigger_in <= 10'h3f7;
      w16(ADDR_CUR_HIGH, 16'h0050);
      w16(ADDR_END_HIGH, 16'h0050);
      bus(1, ADDR_SCAN_CTRL, 8'hc3);
      repeat (20) @(posedge clk_sys);
      chk("no_trig", 16'd8, cnt);
      trigger_in <= 10'h008;
      scan(16'h0000, 16'h0000, 8'hc3);
      chk("words", 16'd9, cnt);
      scan(16'h3fff, 16'h3fff, 8'hc0);
      chk("invalid", 16'h1, {15'h0, q[CTRL_INVALID]});
      rd(ADDR_CUR_HIGH, "cur_h", 8'h40);
      rdy_en <= 0;
      w16(ADDR_CUR_HIGH, 16'h0060);
      w16(ADDR_END_HIGH, 16'h0070);
      bus(1, ADDR_SCAN_CTRL, 8'hc9);
      bus(1, ADDR_SCAN_CTRL, 8'h49);
      rd(ADDR_SCAN_CTRL, "ctrl", 8'h49);
      rd(ADDR_CUR_LOW, "cur_l", 8'h60);
      rdy_en <= 1;
      repeat (20) @(posedge clk_sys);
      chk("disabled", 16'd10, cnt);
      bus(1, ADDR_SCAN_CTRL, 8'h00);
      test_done;
   end
endmodule
`default_nettype wire
